// ===== tlic_regs.svh
// Constants of the two-level interrupt controller
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH

// Program counter width and the two service entry addresses
`define TLIC_PC_W          21
`define TLIC_VEC_HIGH      21'h000008
`define TLIC_VEC_LOW       21'h000018

// Bit positions inside the global enable write word
`define TLIC_GE_HIGH_BIT   1
`define TLIC_GE_LOW_BIT    0

// Reset values of the control bits
`define TLIC_RST_PRIO_MODE 1'h0
`define TLIC_RST_GE        1'h0

// Default number of sources and peripheral membership
`define TLIC_N_SRC         8
`define TLIC_PERIPH_MASK   8'hf8

`endif

// ===== tlic_pkg.sv
// Types shared by the two-level interrupt controller
package tlic_pkg;

    // Level of the most recently accepted interrupt
    typedef enum logic [1:0] {
        TLIC_LVL_NONE,
        TLIC_LVL_HIGH,
        TLIC_LVL_LOW
    } tlic_lvl_t;

endpackage

// ===== tlic_top.sv
// Two-level prioritised interrupt controller for an 8-bit core
`timescale 1ns/1ps
`include "tlic_regs.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module tlic_top #(
    parameter int                  N_SRC       = `TLIC_N_SRC,
    parameter logic [N_SRC-1:0]    PERIPH_MASK = `TLIC_PERIPH_MASK
) (
    // Clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESET,
    // Core timing and return instruction
    input  wire logic                  INSTR_CYCLE_STB,
    input  wire logic                  RETURN_FROM_IRQ_INSTR,
    // Source events, one-cycle pulses from same-clock logic
    input  wire logic [N_SRC-1:0]      SRC_EVENT,
    // Software flag clears, one-cycle pulses
    input  wire logic [N_SRC-1:0]      FLAG_CLR,
    // Per-source enable and priority bits
    input  wire logic [N_SRC-1:0]      SRC_ENABLE,
    input  wire logic [N_SRC-1:0]      SRC_PRIORITY,
    // Software writes of control bits
    input  wire logic                  PRIO_MODE_WR,
    input  wire logic                  PRIO_MODE_WDATA,
    input  wire logic                  GLOBAL_EN_WR,
    input  wire logic [1:0]            GLOBAL_EN_WDATA,
    // Readable state
    output logic [N_SRC-1:0]           FLAGS,
    output logic                       PRIORITY_MODE_ENABLE,
    output logic                       HIGH_LEVEL_GLOBAL_ENABLE,
    output logic                       LOW_LEVEL_GLOBAL_ENABLE,
    output logic                       IN_HIGH_SERVICE,
    output logic                       IN_LOW_SERVICE,
    // Requests to the core sequencer
    output logic                       VECTOR_TAKE,
    output logic                       PUSH_RETURN,
    output logic [`TLIC_PC_W-1:0]      VECTOR_ADDR,
    output tlic_pkg::tlic_lvl_t        TAKEN_LEVEL
);

    ////////////////////////////////////////////////////////////////////////
    // State

    // Whole state of the block in one record
    typedef struct packed {
        logic [N_SRC-1:0]     flags;    // Event flags
        logic                 priority_mode_enable;     // Priority mode enable
        logic                 hge;      // High / single global enable
        logic                 lge;      // Low / peripheral enable
        logic                 in_hi;    // High routine in progress
        logic                 in_lo;    // Low routine in progress
        logic                 req_hi;   // High request seen at the last instruction cycle boundary
        logic                 req_lo;   // Low request seen at the last instruction cycle boundary
        logic                 take;     // Vector pulse
        logic                 push;     // Push return address pulse
        logic [`TLIC_PC_W-1:0] vec;     // Vector to load
        tlic_pkg::tlic_lvl_t  lvl;      // Level of last acceptance
    } tlic_state_t;

    tlic_state_t s_q;                   // Registered state
    tlic_state_t s_d;                   // Next state

    logic [N_SRC-1:0] hi_src;           // Sources qualified at high
    logic [N_SRC-1:0] lo_src;           // Sources qualified at low
    logic             hi_now;           // Any high request now
    logic             lo_now;           // Any low request now

    ////////////////////////////////////////////////////////////////////////
    // Per-source qualification

    // Flag and enable form the request; priority bit picks the level
    // only in priority mode, otherwise every source counts as high
    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++) begin : g_src
            always_comb begin
                if (s_q.priority_mode_enable) begin
                    // Priority bit steers the source
                    hi_src[gi] = s_q.flags[gi] && SRC_ENABLE[gi]
                                 && SRC_PRIORITY[gi];
                    lo_src[gi] = s_q.flags[gi] && SRC_ENABLE[gi]
                                 && !SRC_PRIORITY[gi];
                end else begin
                    // Priority bit ignored; peripherals need lge
                    hi_src[gi] = s_q.flags[gi] && SRC_ENABLE[gi]
                                 && (!PERIPH_MASK[gi] || s_q.lge);
                    lo_src[gi] = 1'h0;
                end
            end
        end
    endgenerate

    // Global gating; low needs both enables, so a high routine
    // (which cleared hge) holds every low request pending
    // Low is also held off while a high routine is marked in progress,
    // so software re-opening hge inside that routine cannot let low in
    always_comb begin
        hi_now = (|hi_src) && s_q.hge;
        lo_now = (|lo_src) && s_q.lge && s_q.hge
                 && !s_q.in_hi;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Flags, writes, return and acceptance in rising order of precedence, acceptance winning
    always_comb begin
        s_d      = s_q;
        s_d.take = 1'h0;
        s_d.push = 1'h0;
        // A new event beats a clear in the same cycle
        s_d.flags = (s_q.flags & ~FLAG_CLR) | SRC_EVENT;
        // Software writes of control bits
        if (PRIO_MODE_WR) begin
            s_d.priority_mode_enable = PRIO_MODE_WDATA;
        end
        if (GLOBAL_EN_WR) begin
            s_d.hge = GLOBAL_EN_WDATA[`TLIC_GE_HIGH_BIT];
            s_d.lge = GLOBAL_EN_WDATA[`TLIC_GE_LOW_BIT];
        end
        // Return re-enables the level being left
        if (RETURN_FROM_IRQ_INSTR) begin
            if (s_q.priority_mode_enable && !s_q.in_hi && s_q.in_lo) begin
                s_d.lge   = 1'h1;
                s_d.in_lo = 1'h0;
            end else begin
                s_d.hge   = 1'h1;
                s_d.in_hi = 1'h0;
            end
        end
        // Judged once per instruction cycle; a request must be seen on
        // two boundaries, so latency does not depend on instruction length
        if (INSTR_CYCLE_STB) begin
            s_d.req_hi = hi_now;
            s_d.req_lo = lo_now;
            if (s_q.req_hi && hi_now) begin
                // High wins over a simultaneous low
                s_d.take   = 1'h1;
                s_d.push   = 1'h1;
                s_d.vec    = `TLIC_VEC_HIGH;
                s_d.hge    = 1'h0;
                s_d.in_hi  = 1'h1;
                s_d.lvl    = tlic_pkg::TLIC_LVL_HIGH;
                s_d.req_hi = 1'h0;
                s_d.req_lo = 1'h0;
            end else if (s_q.req_lo && lo_now) begin
                s_d.take   = 1'h1;
                s_d.push   = 1'h1;
                s_d.vec    = `TLIC_VEC_LOW;
                s_d.lge    = 1'h0;
                s_d.in_lo  = 1'h1;
                s_d.lvl    = tlic_pkg::TLIC_LVL_LOW;
                s_d.req_hi = 1'h0;
                s_d.req_lo = 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Everything resets to constants; priority mode starts off
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            s_q       <= '0;
            s_q.priority_mode_enable  <= `TLIC_RST_PRIO_MODE;
            s_q.hge   <= `TLIC_RST_GE;
            s_q.lge   <= `TLIC_RST_GE;
            s_q.vec   <= `TLIC_VEC_HIGH;
            s_q.lvl   <= tlic_pkg::TLIC_LVL_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state flops

    assign FLAGS                    = s_q.flags;
    assign PRIORITY_MODE_ENABLE     = s_q.priority_mode_enable;
    assign HIGH_LEVEL_GLOBAL_ENABLE = s_q.hge;
    assign LOW_LEVEL_GLOBAL_ENABLE  = s_q.lge;
    assign IN_HIGH_SERVICE          = s_q.in_hi;
    assign IN_LOW_SERVICE           = s_q.in_lo;
    assign VECTOR_TAKE              = s_q.take;
    assign PUSH_RETURN              = s_q.push;
    assign VECTOR_ADDR              = s_q.vec;
    assign TAKEN_LEVEL              = s_q.lvl;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    // High acceptance points at the high vector, low at the low one
    property p_vec_by_level;
        VECTOR_TAKE |-> (TAKEN_LEVEL == tlic_pkg::TLIC_LVL_HIGH
            ? VECTOR_ADDR == `TLIC_VEC_HIGH
            : VECTOR_ADDR == `TLIC_VEC_LOW);
    endproperty
    a_vec_by_level: assert property (p_vec_by_level)
        else $error("vector does not match taken level");

    // Compatibility mode only ever uses the high vector
    property p_compat_single;
        (VECTOR_TAKE && !$past(s_q.priority_mode_enable))
            |-> (VECTOR_ADDR == `TLIC_VEC_HIGH);
    endproperty
    a_compat_single: assert property (p_compat_single)
        else $error("compat mode took the low vector");

    // Accepting clears the matching global enable
    property p_clear_ge;
        VECTOR_TAKE |-> (TAKEN_LEVEL == tlic_pkg::TLIC_LVL_HIGH
            ? !HIGH_LEVEL_GLOBAL_ENABLE : !LOW_LEVEL_GLOBAL_ENABLE);
    endproperty
    a_clear_ge: assert property (p_clear_ge)
        else $error("global enable not cleared on acceptance");

    // Vector load and return-address push come together
    property p_push_with_take;
        VECTOR_TAKE == PUSH_RETURN;
    endproperty
    a_push_with_take: assert property (p_push_with_take)
        else $error("push and vector out of step");

    // No low acceptance during a high routine
    property p_low_waits;
        $past(s_q.in_hi) |-> !(VECTOR_TAKE
            && TAKEN_LEVEL == tlic_pkg::TLIC_LVL_LOW);
    endproperty
    a_low_waits: assert property (p_low_waits)
        else $error("low taken inside high routine");

    // Low acceptance needs both global enables beforehand
    property p_low_needs_both;
        (VECTOR_TAKE && TAKEN_LEVEL == tlic_pkg::TLIC_LVL_LOW)
            |-> $past(s_q.hge && s_q.lge && s_q.priority_mode_enable);
    endproperty
    a_low_needs_both: assert property (p_low_needs_both)
        else $error("low taken without both enables");

    // A confirmed high request preempts a low routine on the next edge
    property p_high_preempts;
        (INSTR_CYCLE_STB && s_q.req_hi && hi_now && s_q.in_lo)
            |=> (VECTOR_TAKE && TAKEN_LEVEL == tlic_pkg::TLIC_LVL_HIGH);
    endproperty
    a_high_preempts: assert property (p_high_preempts)
        else $error("high request did not preempt");

    // Every event shows in its flag one edge later, clear or not
    property p_flag_sets;
        (SRC_EVENT != '0)
            |=> ((FLAGS & $past(SRC_EVENT)) == $past(SRC_EVENT));
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("event lost from flags");

    // Acceptance only follows a request seen one boundary earlier
    property p_two_boundaries;
        VECTOR_TAKE |-> $past(INSTR_CYCLE_STB
            && (s_q.req_hi || s_q.req_lo));
    endproperty
    a_two_boundaries: assert property (p_two_boundaries)
        else $error("vector without prior registered request");

    // Return in compatibility mode sets the single enable again
    property p_return_sets;
        (RETURN_FROM_IRQ_INSTR && !s_q.priority_mode_enable && !INSTR_CYCLE_STB
            && !GLOBAL_EN_WR) |=> HIGH_LEVEL_GLOBAL_ENABLE;
    endproperty
    a_return_sets: assert property (p_return_sets)
        else $error("return did not re-enable");

    // A vector load is a single-cycle pulse, never two in a row
    property p_take_pulse;
        VECTOR_TAKE |=> !VECTOR_TAKE;
    endproperty
    a_take_pulse: assert property (p_take_pulse)
        else $error("vector load longer than one cycle");

    // Compatibility acceptance needs the single global enable
    property p_compat_needs_ge;
        (VECTOR_TAKE && !$past(s_q.priority_mode_enable)) |-> $past(s_q.hge);
    endproperty
    a_compat_needs_ge: assert property (p_compat_needs_ge)
        else $error("compat vector without global enable");

endmodule

// ===== tlic_core_model.sv
// Core sequencer and return stack model facing the controller
`timescale 1ns/1ps
module tlic_core_model #(
    parameter int CYC_CLKS = 4  // Clocks per instruction cycle
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bench command and controller requests
    input  wire logic ret_req,
    input  wire logic take,
    input  wire logic push,
    // Core outputs
    output logic      stb,
    output logic      ret,
    output int        depth
);
    int phase;  // Position inside the instruction cycle
    ////////////////////////////////////////////////////////////
    // Boundary strobe moves on the falling edge, away from sampling
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            phase <= 0;
            stb   <= 1'h0;
        end else begin
            phase <= (phase + 1) % CYC_CLKS;
            stb   <= (phase == CYC_CLKS - 2);
        end
    end
    // Core runs the return instruction when the bench orders it
    assign ret = ret_req;
    // Hardware stack: a push that comes with its vector load counts and
    // a return pops, so a take or a push alone leaves a depth error
    always @(posedge clk or posedge rst) begin
        if (rst)
            depth <= 0;
        else
            depth <= depth + int'(take && push) - int'(ret);
    end
endmodule

// ===== tlic_tb_top.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`include "tlic_regs.svh"
module tlic_tb_top;
    localparam int CYC = 4;  // Clocks per instruction cycle
    localparam logic [20:0] VH = `TLIC_VEC_HIGH;
    localparam logic [20:0] VL = `TLIC_VEC_LOW;
    localparam tlic_pkg::tlic_lvl_t LH = tlic_pkg::TLIC_LVL_HIGH;
    localparam tlic_pkg::tlic_lvl_t LL = tlic_pkg::TLIC_LVL_LOW;
    localparam tlic_pkg::tlic_lvl_t LN = tlic_pkg::TLIC_LVL_NONE;
    // One ordinary case: mode, enables, source, outcome
    typedef struct packed {
        logic pm; logic [1:0] ge; int src; logic pr; logic en;
        logic take; logic [20:0] addr; tlic_pkg::tlic_lvl_t lvl;
    } tlic_row_t;
    tlic_row_t rows [10] = '{
        '{1'h0, 2'h2, 0, 1'h0, 1'h1, 1'h1, VH, LH},
        '{1'h0, 2'h2, 3, 1'h0, 1'h1, 1'h0, VH, LN},
        '{1'h0, 2'h3, 3, 1'h0, 1'h1, 1'h1, VH, LH},
        '{1'h0, 2'h3, 5, 1'h1, 1'h1, 1'h1, VH, LH},
        '{1'h0, 2'h1, 0, 1'h0, 1'h1, 1'h0, VH, LN},
        '{1'h1, 2'h2, 1, 1'h1, 1'h1, 1'h1, VH, LH},
        '{1'h1, 2'h2, 1, 1'h0, 1'h1, 1'h0, VH, LN},
        '{1'h1, 2'h3, 4, 1'h0, 1'h1, 1'h1, VL, LL},
        '{1'h1, 2'h1, 4, 1'h0, 1'h1, 1'h0, VH, LN},
        '{1'h1, 2'h3, 2, 1'h1, 1'h0, 1'h0, VH, LN}};
    logic sys_clk, reset, ret_req, stb, ret;  // Clock, reset, core
    logic [7:0] src_event, flag_clr, src_enable, src_priority, flags;
    logic prio_mode_wr, prio_mode_wdata, global_en_wr;  // Writes
    logic [1:0] global_en_wdata, exp_ge;
    logic pme, hge, lge, in_high, in_low, vector_take, push_return;
    logic [20:0] vector_addr;
    tlic_pkg::tlic_lvl_t taken_level;
    int depth, n, miscompares, comparisons;
    tlic_row_t r;
    tlic_top i_tlic_top (.SYS_CLK(sys_clk), .RESET(reset),
        .INSTR_CYCLE_STB(stb), .RETURN_FROM_IRQ_INSTR(ret),
        .SRC_EVENT(src_event), .FLAG_CLR(flag_clr),
        .SRC_ENABLE(src_enable), .SRC_PRIORITY(src_priority),
        .PRIO_MODE_WR(prio_mode_wr), .PRIO_MODE_WDATA(prio_mode_wdata),
        .GLOBAL_EN_WR(global_en_wr), .GLOBAL_EN_WDATA(global_en_wdata),
        .FLAGS(flags), .PRIORITY_MODE_ENABLE(pme),
        .HIGH_LEVEL_GLOBAL_ENABLE(hge), .LOW_LEVEL_GLOBAL_ENABLE(lge),
        .IN_HIGH_SERVICE(in_high), .IN_LOW_SERVICE(in_low),
        .VECTOR_TAKE(vector_take), .PUSH_RETURN(push_return),
        .VECTOR_ADDR(vector_addr), .TAKEN_LEVEL(taken_level));
    tlic_core_model #(.CYC_CLKS(CYC)) i_tlic_core_model (.clk(sys_clk),
        .rst(reset), .ret_req(ret_req), .take(vector_take),
        .push(push_return), .stb(stb), .ret(ret), .depth(depth));
    always #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic bad(input string msg);
        $display("BAD %0t %s", $time, msg);
        miscompares++;
    endtask
    // One-cycle pulses: 0 events, 1 flag clears, 2 return
    task automatic pulse(input int kind, input logic [7:0] m);
        @(negedge sys_clk);
        case (kind)
            0: src_event = m;
            1: flag_clr = m;
            default: ret_req = 1'h1;
        endcase
        @(negedge sys_clk);
        src_event = 8'h00;
        flag_clr = 8'h00;
        ret_req = 1'h0;
    endtask
    // Control bits are written directly, never by memory moves
    task automatic setup(logic pm, logic [1:0] ge, logic [7:0] en,
                         logic [7:0] pr);
        @(negedge sys_clk);
        {prio_mode_wr, prio_mode_wdata, global_en_wr} = {1'h1, pm, 1'h1};
        {global_en_wdata, src_enable, src_priority} = {ge, en, pr};
        @(negedge sys_clk);
        {prio_mode_wr, global_en_wr} = 2'h0;
    endtask
    // Bounded wait for acceptance; a lost take ends the run
    task automatic expect_take(logic [20:0] a, tlic_pkg::tlic_lvl_t l,
                               output int cnt);
        cnt = 0;
        while (vector_take !== 1'h1 && cnt < 40) begin
            @(negedge sys_clk);
            cnt++;
        end
        comparisons++;
        if (vector_take !== 1'h1) begin
            bad("no vector taken");
            stop_test();
        end else begin
            if (vector_addr !== a || taken_level !== l) bad("vector");
            if (push_return !== 1'h1) bad("no push");
            @(negedge sys_clk);
            if (vector_take !== 1'h0) bad("take not a pulse");
        end
    endtask
    // Request must stay pending for several instruction cycles
    task automatic expect_none();
        comparisons++;
        repeat (3 * CYC + 4) begin
            @(negedge sys_clk);
            if (vector_take !== 1'h0) bad("unexpected vector");
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {sys_clk, reset, ret_req, prio_mode_wr, prio_mode_wdata} = 5'h08;
        {global_en_wr, global_en_wdata} = 3'h0;
        {src_event, flag_clr, src_enable, src_priority} = 32'h0;
        {miscompares, comparisons} = 64'h0;
        repeat (5) @(negedge sys_clk);
        reset = 1'h0;
        // Table rows: gating, vectors and enable handling per mode
        foreach (rows[i]) begin
            r = rows[i];
            setup(r.pm, r.ge, r.en ? 8'h01 << r.src : 8'h00, {8{r.pr}});
            if (pme !== r.pm) bad("mode write");
            pulse(0, 8'h01 << r.src);
            if (r.take) begin
                expect_take(r.addr, r.lvl, n);
                if (n < CYC + 1 || n > 2 * CYC + 2) bad("latency");
                exp_ge = (r.lvl == LL) ? {r.ge[1], 1'h0} : {1'h0, r.ge[0]};
                if ({hge, lge} !== exp_ge) bad("enable not cleared");
                pulse(1, 8'h01 << r.src);
                pulse(2, 8'h00);
                if ({hge, lge} !== r.ge || depth !== 0) bad("return");
            end else begin
                expect_none();
                if (flags[r.src] !== 1'h1) bad("flag not set");
                pulse(1, 8'h01 << r.src);
            end
        end
        // Mid-run reset with a flag up and priority mode on
        pulse(0, 8'h40);
        reset = 1'h1;
        @(negedge sys_clk);
        comparisons++;
        if (pme !== 1'h0 || {hge, lge} !== 2'h0) bad("reset mode");
        if (flags !== 8'h00 || vector_addr !== VH) bad("reset state");
        if (taken_level !== LN || {in_high, in_low} !== 2'h0) bad("lvl");
        reset = 1'h0;
        // Simultaneous requests, pending low, then preemption
        setup(1'h1, 2'h3, 8'h11, 8'h01);
        pulse(0, 8'h11);
        expect_take(VH, LH, n);
        expect_none();
        pulse(1, 8'h01);
        pulse(2, 8'h00);
        expect_take(VL, LL, n);
        pulse(0, 8'h01);
        expect_take(VH, LH, n);
        if (depth !== 2 || {in_high, in_low} !== 2'h3) bad("nest");
        pulse(1, 8'h11);
        pulse(2, 8'h00);
        pulse(2, 8'h00);
        if ({hge, lge} !== 2'h3 || depth !== 0) bad("unwind");
        if ({in_high, in_low} !== 2'h0) bad("unwound levels");
        stop_test();
    end
endmodule
